// file: verilog/tcu_top.sv
// timer compare unit: five compare/pwm channels, register port, interrupt
// assumes timer count, tick, period timer and converter status come from
// logic on this same clock; the pin direction bit lives outside
//
// Contract
// RL1 - five identical units with own registers
// RL2 - compare 16-bit value against timer count
// RL3 - mode selects set, clear, toggle, flag, trigger
// RL4 - every match sets flag with action
// RL5 - flag-only mode leaves pin uncontrolled
// RL6 - trigger mode resets timer, no pin
// RL7 - unit five starts conversion when enabled
// RL8 - trigger immediate, timer clear at tick; a trigger in a tick cycle gives no clear
// RL9 - lost match before tick cancels clear
// RL10 - trigger clear never sets overflow flag
// RL11 - zero control forces compare latch low
// RL12 - timer runs synchronous while comparing
// RL13 - outside clears pin direction bit
// RL14 - no matching while clock stopped
// RL15 - pwm output with 10-bit duty
// RL16 - zero control releases the pin
// RL17 - mode codes fixed in header
`timescale 1ns/1ns
`default_nettype none
`include "tcu_consts.svh"
module tcu_top
	import tcu_pkg::*;
#(
	parameter int UNITS = `TCU_UNITS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	// timer count and its clock tick
	input wire logic [15:0] timer_count,
	input wire logic timer_tick,
	output logic timer_clear,
	output logic timer_overflow_flag,
	// pwm period timer
	input wire logic [9:0] pwm_time_base,
	input wire logic pwm_period_hit,
	// converter
	input wire logic converter_enabled,
	output logic converter_start,
	// pins
	output logic [UNITS-1:0] unit_output_pin,
	output logic [UNITS-1:0] unit_pin_own,
	output logic [UNITS-1:0] special_event_trigger,
	// interrupt
	output logic irq
);
	initial begin
		if (UNITS < 1 || UNITS > `TCU_UNITS) $error("unit count not served"); // RL1
	end

	////////////////////////////////////////////////////////////////
	// per-unit registers and results
	logic [7:0] unit_control [UNITS]; // control byte per unit
	logic [7:0] match_value_low [UNITS]; // compare low byte
	logic [7:0] match_value_high [UNITS]; // compare high byte
	logic [UNITS-1:0] match_interrupt_flag; // sticky match flags
	logic [UNITS-1:0] match_interrupt_enable; // interrupt mask
	logic [UNITS-1:0] match_now; // pairs equal this cycle
	logic [UNITS-1:0] match_pulse; // entry into a match
	logic [UNITS-1:0] clear_pending; // trigger waiting for tick
	logic [UNITS-1:0] cmp_latch; // compare output latches
	logic [UNITS-1:0] cmp_drive; // compare owns the pin
	logic [UNITS-1:0] pwm_level; // pwm output levels
	logic [UNITS-1:0] pwm_on; // unit in pwm mode
	logic [UNITS-1:0] unit_hit; // address falls in unit block
	logic [UNITS-1:0] clear_write; // write-one-to-clear bits
	logic status_hit; // address is the status register
	logic mask_hit; // address is the mask register

	// unit block selected by an address, one bit per unit
	function automatic logic [UNITS-1:0] unit_select(input logic [7:0] addr);
		logic [UNITS-1:0] sel;
		sel = '0;
		for (int n = 0; n < UNITS; n++) begin
			if (addr[7:`TCU_UNIT_SHIFT] == 6'(n) && addr[1:0] != 2'h3) sel[n] = 1'b1;
		end
		return sel;
	endfunction

	assign unit_hit = unit_select(reg_addr);
	assign status_hit = (reg_addr == `TCU_OFS_STATUS);
	assign mask_hit = (reg_addr == `TCU_OFS_MASK);
	assign clear_write = (reg_write && status_hit) ? reg_wdata[UNITS-1:0] : '0;

	////////////////////////////////////////////////////////////////
	// channels: one compare and one pwm block per unit
	generate
		for (genvar g = 0; g < UNITS; g++) begin : gen_unit
			logic [3:0] mode; // mode field of this unit
			assign mode = unit_control[g][`TCU_MODE_MSB:`TCU_MODE_LSB];
			assign pwm_on[g] = (tcu_decode(mode) == TCU_ACT_PWM);

			tcu_compare u_compare (
				.clock(clock),
				.rst(rst),
				.mode(mode),
				.control_zero(unit_control[g] == `TCU_RESET_BYTE),
				.value({match_value_high[g], match_value_low[g]}), // RL2
				.count(timer_count), // RL12
				.match_now(match_now[g]),
				.match_pulse(match_pulse[g]),
				.latch(cmp_latch[g]),
				.drive(cmp_drive[g])
			);

			tcu_pwm #(.DUTY_BITS(`TCU_DUTY_BITS)) u_pwm (
				.clock(clock),
				.rst(rst),
				.enable(pwm_on[g]),
				.duty({match_value_low[g],
					unit_control[g][`TCU_DUTY_MSB:`TCU_DUTY_LSB]}), // RL15
				.time_base(pwm_time_base),
				.period_hit(pwm_period_hit),
				.level(pwm_level[g])
			);

			// trigger asserts in the match cycle itself
			assign special_event_trigger[g] = match_pulse[g]
				& (tcu_decode(mode) == TCU_ACT_TRIGGER); // RL6 RL8
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// pin ownership: zero control or flag/trigger modes release it
	always_comb begin
		for (int n = 0; n < UNITS; n++) begin
			unit_pin_own[n] = cmp_drive[n] | pwm_on[n]; // RL5 RL6 RL16 RL13
			unit_output_pin[n] = pwm_on[n] ? pwm_level[n] : cmp_latch[n];
		end
	end

	////////////////////////////////////////////////////////////////
	// only unit five starts a conversion, and only when enabled
	assign converter_start = (UNITS == `TCU_UNITS)
		? special_event_trigger[UNITS-1] & converter_enabled : 1'b0; // RL7

	////////////////////////////////////////////////////////////////
	// a trigger off a tick pends to the next tick, which clears the timer if the match holds; a trigger in a tick cycle is dropped
	always_ff @(posedge clock) begin
		if (rst) clear_pending <= '0;
		else if (timer_tick) clear_pending <= '0;
		else clear_pending <= clear_pending | special_event_trigger; // RL8
	end
	assign timer_clear = timer_tick & |(clear_pending & match_now); // RL8 RL9
	// a trigger clear is not an overflow, so this flag is never raised here
	assign timer_overflow_flag = 1'b0; // RL10

	////////////////////////////////////////////////////////////////
	// unit register writes
	always_ff @(posedge clock) begin
		if (rst) begin
			for (int n = 0; n < UNITS; n++) begin
				unit_control[n] <= `TCU_RESET_BYTE;
				match_value_low[n] <= `TCU_RESET_BYTE;
				match_value_high[n] <= `TCU_RESET_BYTE;
			end
		end else if (reg_write) begin
			for (int n = 0; n < UNITS; n++) begin
				if (unit_hit[n]) begin
					case (reg_addr[1:0])
						`TCU_OFS_CONTROL: unit_control[n] <= reg_wdata; // RL17
						`TCU_OFS_LOW: match_value_low[n] <= reg_wdata;
						`TCU_OFS_HIGH: match_value_high[n] <= reg_wdata;
						default: ;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// sticky match flags: a new match wins over a clear
	always_ff @(posedge clock) begin
		if (rst) match_interrupt_flag <= `TCU_RESET_UNITS;
		else match_interrupt_flag <= (match_interrupt_flag & ~clear_write) | match_pulse; // RL4
	end

	////////////////////////////////////////////////////////////////
	// interrupt mask
	always_ff @(posedge clock) begin
		if (rst) match_interrupt_enable <= `TCU_RESET_UNITS;
		else if (reg_write && mask_hit) match_interrupt_enable <= reg_wdata[UNITS-1:0];
	end
	assign irq = |(match_interrupt_flag & match_interrupt_enable);

	////////////////////////////////////////////////////////////////
	// read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock) begin
		if (rst) reg_rdata <= `TCU_RESET_BYTE;
		else if (reg_read) begin
			reg_rdata <= `TCU_RESET_BYTE;
			if (status_hit) reg_rdata <= 8'(match_interrupt_flag);
			else if (mask_hit) reg_rdata <= 8'(match_interrupt_enable);
			else begin
				for (int n = 0; n < UNITS; n++) begin
					if (unit_hit[n]) begin
						case (reg_addr[1:0])
							`TCU_OFS_CONTROL: reg_rdata <= unit_control[n];
							`TCU_OFS_LOW: reg_rdata <= match_value_low[n];
							`TCU_OFS_HIGH: reg_rdata <= match_value_high[n];
							default: reg_rdata <= `TCU_RESET_BYTE;
						endcase
					end
				end
			end
		end else reg_rdata <= `TCU_RESET_BYTE;
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// a trigger away from a tick, then a pending trigger still matching at the tick
	sequence trig_seq;
		special_event_trigger[0] && !timer_tick;
	endsequence
	sequence held_to_tick;
		clear_pending[0] && match_now[0] && timer_tick;
	endsequence
	// a pending trigger on unit three whose match was lost before the tick
	sequence lost_seq;
		clear_pending == 5'h04 && !match_now[2] && timer_tick;
	endsequence

	flag_on_match_a: assert property (match_pulse[0] |=> match_interrupt_flag[0]) // RL4
		else $error("match did not set flag");
	flag_set_wins_a: assert property (match_pulse[1] && clear_write[1]
		|=> match_interrupt_flag[1]) // RL4
		else $error("clear beat a new match");
	trigger_pends_a: assert property (trig_seq |=> clear_pending[0]) // RL8
		else $error("trigger did not wait for tick");
	trigger_clears_timer_a: assert property (held_to_tick |-> timer_clear) // RL8
		else $error("held trigger gave no timer clear");
	lost_match_no_clear_a: assert property (lost_seq |-> !timer_clear) // RL9
		else $error("timer cleared without match");
	no_overflow_set_a: assert property (timer_clear |-> !timer_overflow_flag) // RL10
		else $error("trigger clear set overflow");
	zero_control_latch_a: assert property (unit_control[2] == 8'h00
		|-> !unit_pin_own[2] ##1 !cmp_latch[2]) // RL11 RL16
		else $error("zero control left pin held");
	flag_mode_free_a: assert property (tcu_decode(unit_control[3][3:0]) == TCU_ACT_FLAG
		|-> !unit_pin_own[3]) // RL5
		else $error("flag mode owns pin");
	converter_gate_a: assert property (converter_start
		|-> special_event_trigger[UNITS-1] && converter_enabled) // RL7
		else $error("conversion start without cause");
	toggle_flip_a: assert property (match_pulse[0] && unit_control[0][3:0] == 4'h2
		&& unit_control[0] != 8'h00 |=> cmp_latch[0] != $past(cmp_latch[0])) // RL3
		else $error("toggle did not flip");
	read_late_a: assert property (reg_read && reg_addr == 8'h15
		|=> reg_rdata == 8'($past(match_interrupt_enable))) // RL1
		else $error("mask read wrong");
endmodule
`default_nettype wire

// file: common/tcu_consts.svh
// timer compare unit: offsets, field positions, mode codes and reset values
// assumes inclusion by bare name from the package and the design files
`ifndef TCU_CONSTS_SVH
`define TCU_CONSTS_SVH
// number of compare units
`define TCU_UNITS 5
// unit register index inside each unit's block of four words
`define TCU_OFS_CONTROL 2'h0
`define TCU_OFS_LOW 2'h1
`define TCU_OFS_HIGH 2'h2
// unit block stride is four addresses; unit n sits at n*4
`define TCU_UNIT_SHIFT 2
// shared interrupt registers
`define TCU_OFS_STATUS 8'h14
`define TCU_OFS_MASK 8'h15
// control field positions
`define TCU_MODE_LSB 0
`define TCU_MODE_MSB 3
`define TCU_DUTY_LSB 4
`define TCU_DUTY_MSB 5
// mode field codes
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_TOGGLE 4'h2
`define TCU_MODE_SET 4'h8
`define TCU_MODE_CLEAR 4'h9
`define TCU_MODE_FLAG 4'ha
`define TCU_MODE_TRIGGER 4'hb
// any code with both top bits set selects pwm
`define TCU_MODE_PWM_TOP 2'h3
// reset values
`define TCU_RESET_BYTE 8'h00
`define TCU_RESET_UNITS 5'h00
// pwm duty width
`define TCU_DUTY_BITS 10
`endif

// file: common/tcu_pkg.sv
// timer compare unit: shared types and the mode decode
// assumes tcu_consts.svh is on the include path
`include "tcu_consts.svh"
package tcu_pkg;
	// one-hot match action selected by the mode field
	typedef enum logic [6:0] {
		TCU_ACT_OFF = 7'b0000001,
		TCU_ACT_SET = 7'b0000010,
		TCU_ACT_CLEAR = 7'b0000100,
		TCU_ACT_TOGGLE = 7'b0001000,
		TCU_ACT_FLAG = 7'b0010000,
		TCU_ACT_TRIGGER = 7'b0100000,
		TCU_ACT_PWM = 7'b1000000
	} tcu_act_type;
	// decode a mode field into its action; unlisted codes act as off
	function automatic tcu_act_type tcu_decode(input logic [3:0] mode);
		tcu_act_type act;
		act = TCU_ACT_OFF;
		if (mode[3:2] == `TCU_MODE_PWM_TOP) act = TCU_ACT_PWM;
		else begin
			case (mode)
				`TCU_MODE_SET: act = TCU_ACT_SET;
				`TCU_MODE_CLEAR: act = TCU_ACT_CLEAR;
				`TCU_MODE_TOGGLE: act = TCU_ACT_TOGGLE;
				`TCU_MODE_FLAG: act = TCU_ACT_FLAG;
				`TCU_MODE_TRIGGER: act = TCU_ACT_TRIGGER;
				default: act = TCU_ACT_OFF;
			endcase
		end
		return act;
	endfunction
endpackage

// file: verilog/tcu_compare.sv
// one compare channel: match detection and the compare output latch
// assumes timer count comes from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module tcu_compare
	import tcu_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// configuration
	input wire logic [3:0] mode,
	input wire logic control_zero,
	input wire logic [15:0] value,
	// timer
	input wire logic [15:0] count,
	// results
	output logic match_now,
	output logic match_pulse,
	output logic latch,
	output logic drive
);
	tcu_act_type act; // decoded action
	logic match_q; // match seen last cycle

	assign act = tcu_decode(mode);
	// equality of the two 16-bit pairs, checked every cycle
	assign match_now = (value == count); // RL2
	// one event per entry into the match, in any compare mode
	assign match_pulse = match_now & ~match_q & (act != TCU_ACT_OFF) & (act != TCU_ACT_PWM);
	// only set, clear and toggle take the pin
	assign drive = (act == TCU_ACT_SET) | (act == TCU_ACT_CLEAR) | (act == TCU_ACT_TOGGLE); // RL5 RL6

	////////////////////////////////////////////////////////////////
	// remember the previous match so a held match fires once
	// matches are only seen on system clock edges; a stopped clock sees none
	always_ff @(posedge clock) begin
		if (rst) match_q <= 1'b0;
		else match_q <= match_now; // RL14
	end

	////////////////////////////////////////////////////////////////
	// compare output latch
	always_ff @(posedge clock) begin
		if (rst) latch <= 1'b0;
		else if (control_zero) latch <= 1'b0; // RL11
		else if (match_pulse) begin
			case (act)
				TCU_ACT_SET: latch <= 1'b1; // RL3
				TCU_ACT_CLEAR: latch <= 1'b0; // RL3
				TCU_ACT_TOGGLE: latch <= ~latch; // RL3
				default: latch <= latch;
			endcase
		end
	end
endmodule
`default_nettype wire

// file: verilog/tcu_pwm.sv
// one pwm channel: double-buffered 10-bit duty against a 10-bit time base
// assumes time base and period pulse come from a period timer on this clock
`timescale 1ns/1ns
`default_nettype none
`include "tcu_consts.svh"
module tcu_pwm #(
	parameter int DUTY_BITS = `TCU_DUTY_BITS
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// configuration
	input wire logic enable,
	input wire logic [DUTY_BITS-1:0] duty,
	// period timer
	input wire logic [DUTY_BITS-1:0] time_base,
	input wire logic period_hit,
	// output level
	output logic level
);
	logic [DUTY_BITS-1:0] duty_held; // latched duty for this period

	initial begin
		if (DUTY_BITS < 2 || DUTY_BITS > 10) $error("duty width out of range");
	end

	////////////////////////////////////////////////////////////////
	// duty buffer loads only at the period end for glitchless output
	always_ff @(posedge clock) begin
		if (rst) duty_held <= '0;
		else if (period_hit) duty_held <= duty;
	end

	////////////////////////////////////////////////////////////////
	// set at period start unless duty is zero; clear one step early so the
	// output stays high for exactly duty time-base steps
	always_ff @(posedge clock) begin
		if (rst || !enable) level <= 1'b0;
		else if (period_hit) level <= (duty != '0); // RL15
		else if (time_base == duty_held - DUTY_BITS'(1)) level <= 1'b0; // RL15
	end
endmodule
`default_nettype wire

// file: tb/tcu_timer_model.sv
// timer, period timer and pad model for the compare unit bench
// assumes one clock; bench owns run and load of the timer
`timescale 1ns/1ns
`default_nettype none
module tcu_timer_model #(
	parameter int PERIOD = 31
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// bench control
	input wire logic run,
	input wire logic load,
	input wire logic [15:0] load_value,
	// timer side
	input wire logic timer_clear,
	output logic [15:0] timer_count,
	output logic timer_tick,
	// pwm period timer
	output logic [9:0] pwm_time_base,
	output logic pwm_period_hit,
	// pins and pads
	input wire logic [4:0] pin,
	input wire logic [4:0] own,
	output logic [4:0] pad
);
	logic [1:0] div; // tick divider
	// tick every fourth clock while running, same clock domain
	always_ff @(posedge clock) begin
		if (rst) div <= 2'h0;
		else if (run) div <= div + 2'h1;
	end
	assign timer_tick = run && (div == 2'h3);
	// count loads, clears at a tick on request, else counts at a tick
	always_ff @(posedge clock) begin
		if (rst) timer_count <= 16'h0000;
		else if (load) timer_count <= load_value;
		else if (timer_tick) timer_count <= timer_clear ? 16'h0000 : timer_count + 16'h0001;
	end
	// pwm time base wraps after the period value
	always_ff @(posedge clock) begin
		if (rst || pwm_period_hit) pwm_time_base <= 10'h000;
		else pwm_time_base <= pwm_time_base + 10'h001;
	end
	assign pwm_period_hit = pwm_time_base == 10'(PERIOD);
	// direction bits cleared; undriven pads float up to the pull-up
	assign pad = (own & pin) | ~own;
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the timer compare unit
// assumes the design package, consts header and timer model
`timescale 1ns/1ns
`default_nettype none
`include "tcu_consts.svh"
module tb;
	import tcu_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic [15:0] timer_count, load_value = 16'h0000;
	logic timer_tick, timer_clear, timer_overflow_flag, pwm_period_hit, converter_start, irq;
	logic [9:0] pwm_time_base;
	logic converter_enabled = 1'b0;
	logic run = 1'b0;
	logic load = 1'b0;
	logic [4:0] unit_output_pin, unit_pin_own, special_event_trigger, pad;
	logic [7:0] mask_val, d;
	logic [15:0] v16;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_trig = 0;
	int n_conv = 0;
	int n_clear = 0;
	int n_ovf = 0;
	int hi;
	////////////////////////////////////////////////////////////////
	// clock, design and partner
	always #50 clock = ~clock;
	tcu_top dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.timer_count(timer_count), .timer_tick(timer_tick), .timer_clear(timer_clear),
		.timer_overflow_flag(timer_overflow_flag), .pwm_time_base(pwm_time_base),
		.pwm_period_hit(pwm_period_hit), .converter_enabled(converter_enabled),
		.converter_start(converter_start), .unit_output_pin(unit_output_pin),
		.unit_pin_own(unit_pin_own), .special_event_trigger(special_event_trigger), .irq(irq));
	tcu_timer_model model (.clock(clock), .rst(rst), .run(run), .load(load),
		.load_value(load_value), .timer_clear(timer_clear), .timer_count(timer_count),
		.timer_tick(timer_tick), .pwm_time_base(pwm_time_base),
		.pwm_period_hit(pwm_period_hit), .pin(unit_output_pin), .own(unit_pin_own), .pad(pad));
	// event counters
	always @(posedge clock) begin
		if (!rst) begin
			n_trig += $countones(special_event_trigger);
			n_conv += int'(converter_start);
			n_clear += int'(timer_clear && timer_tick);
			n_ovf += int'(timer_overflow_flag);
		end
	end
	////////////////////////////////////////////////////////////////
	// verdict and compare
	task complete_run;
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// register port, timer load and scenario tasks
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		@(posedge clock);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] v);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		v = reg_rdata;
		@(posedge clock);
	endtask
	task set_count(input logic [15:0] v);
		load_value <= v;
		load <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
	endtask
	function automatic logic [15:0] val_of(input int u);
		return 16'h0200 + 16'(u * 17);
	endfunction
	// one match in mode m, then pin, pad, irq and flag checks
	task step(input int u, input logic [3:0] m, input logic ep, input logic eo, input logic ef);
		set_count(16'h0000);
		wr(8'(u * 4), {4'h0, m});
		set_count(val_of(u));
		@(posedge clock);
		#1;
		if (eo) chk(16'(unit_output_pin[u]), 16'(ep));
		chk(16'(unit_pin_own[u]), 16'(eo));
		chk(16'(pad[u]), 16'(eo ? ep : 1'b1));
		chk(16'(irq), 16'(ef & mask_val[u]));
		@(posedge clock);
		rd(`TCU_OFS_STATUS, d);
		chk(16'(d), 16'(ef) << u);
		wr(`TCU_OFS_STATUS, 8'h1f);
		rd(`TCU_OFS_STATUS, d);
		chk(16'(d), 16'h0000);
	endtask
	// trigger match on unit u, optional value change before the tick
	task trig(input int u, input logic en, input logic nv);
		int t0, c0, k0;
		t0 = n_trig;
		c0 = n_conv;
		k0 = n_clear;
		converter_enabled <= en;
		set_count(16'h0040);
		wr(8'(u * 4 + 1), 8'h23);
		wr(8'(u * 4 + 2), 8'h01);
		wr(8'(u * 4), {4'h0, `TCU_MODE_TRIGGER});
		set_count(16'h0123);
		repeat (3) @(posedge clock);
		chk(16'(n_trig - t0), 16'h0001);
		chk(16'(n_conv - c0), 16'(u == 4 && en));
		chk(16'(unit_pin_own[u]), 16'h0000);
		if (nv) wr(8'(u * 4 + 2), 8'h05);
		run <= 1'b1;
		repeat (8) @(posedge clock);
		run <= 1'b0;
		chk(16'(n_clear - k0), 16'(!nv));
		wr(8'(u * 4), 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		complete_run;
	end
	// main sequence
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		wr(8'h03, 8'hff);
		wr(8'h16, 8'hff);
		for (int a = 0; a <= 8'h16; a++) begin
			rd(8'(a), d);
			chk(16'(d), 16'h0000);
		end
		mask_val = 8'h1f;
		wr(`TCU_OFS_MASK, mask_val);
		for (int u = 0; u < 5; u++) begin
			v16 = val_of(u);
			wr(8'(u * 4 + 1), v16[7:0]);
			wr(8'(u * 4 + 2), v16[15:8]);
			rd(8'(u * 4 + 1), d);
			chk(16'(d), 16'(v16[7:0]));
			rd(8'(u * 4 + 2), d);
			chk(16'(d), 16'(v16[15:8]));
			step(u, `TCU_MODE_SET, 1'b1, 1'b1, 1'b1);
			step(u, `TCU_MODE_CLEAR, 1'b0, 1'b1, 1'b1);
			step(u, `TCU_MODE_TOGGLE, 1'b1, 1'b1, 1'b1);
			wr(8'(u * 4), 8'h00);
			#1;
			chk(16'(unit_output_pin[u]), 16'h0000);
			chk(16'(unit_pin_own[u]), 16'h0000);
			@(posedge clock);
			step(u, `TCU_MODE_OFF, 1'b0, 1'b0, 1'b0);
			step(u, `TCU_MODE_FLAG, 1'b0, 1'b0, 1'b1);
			wr(8'(u * 4), 8'h00);
		end
		mask_val = 8'h00;
		wr(`TCU_OFS_MASK, mask_val);
		step(1, `TCU_MODE_FLAG, 1'b0, 1'b0, 1'b1);
		// a new match and a clear of the same flag in one cycle: the set wins
		set_count(16'h0000);
		@(posedge clock);
		set_count(val_of(1));
		wr(`TCU_OFS_STATUS, 8'h02);
		rd(`TCU_OFS_STATUS, d);
		chk(16'(d), 16'h0002);
		wr(`TCU_OFS_STATUS, 8'h1f);
		wr(8'h04, 8'h00);
		rd(`TCU_OFS_MASK, d);
		chk(16'(d), 16'h0000);
		trig(4, 1'b1, 1'b0);
		trig(4, 1'b0, 1'b0);
		trig(0, 1'b1, 1'b0);
		trig(2, 1'b1, 1'b1);
		wr(8'h01, 8'h02);
		wr(8'h00, 8'h0c);
		repeat (96) @(posedge clock);
		hi = 0;
		repeat (128) begin
			@(posedge clock);
			hi += int'(unit_output_pin[0]);
		end
		chk(16'(hi), 16'h0020);
		chk(16'(unit_pin_own[0]), 16'h0001);
		wr(8'h00, 8'h00);
		chk(16'(unit_pin_own[0]), 16'h0000);
		chk(16'(n_ovf), 16'h0000);
		complete_run;
	end
endmodule
`default_nettype wire
